/* File: hdl/ccr_map.vh */
`ifndef CCR_MAP_VH
`define CCR_MAP_VH
// Register offsets
`define CCR_ADDR_SYSREF_STATUS 8'h2C
`define CCR_ADDR_FULLSCALE 8'h30
`define CCR_ADDR_POWER_PROFILE 8'h37
`define CCR_ADDR_TIMESTAMP_CTRL 8'h3B
`define CCR_ADDR_REFOUT_CTRL 8'h3C
`define CCR_ADDR_FBDIV_VP 8'h3D
// Reset values
`define CCR_RST_SYSREF_STATUS 24'h00_0000
`define CCR_RST_FULLSCALE 16'hA000
`define CCR_RST_POWER_PROFILE 8'h4B
`define CCR_RST_TIMESTAMP_CTRL 8'h00
`define CCR_RST_REFOUT_CTRL 8'h01
`define CCR_RST_FBDIV_VP 8'h00
// Power profile codes
`define CCR_PROFILE_LOW_POWER 8'h46
`define CCR_PROFILE_HIGH_PERF 8'h4B
// Field positions
`define CCR_BIT_TS_ENABLE 0
`define CCR_BIT_TS_LOW_SWING 1
`define CCR_BIT_REFOUT_ENABLE 0
`endif

/* File: hdl/ccr_status_hold.v */
`timescale 1ns/100ps
`include "ccr_map.vh"
// Holds the edge-position word; loads only on a capture strobe
module ccr_status_hold
(
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [23:0] load_data,
  output reg [23:0] held
);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      held <= `CCR_RST_SYSREF_STATUS;
    else if (load)
      held <= load_data;
  end
endmodule // ccr_status_hold

/* File: hdl/ccr_config_regs.v */
// Overview of operation
// - A 24-bit status word reports SYSREF edge position against sampling clock.
// - Edge status is read-only, resets to zero, ignores host writes.
// - One 16-bit full-scale code for all channels, reset 0xA000.
// - Power profile code resets 0x4B; 0x46 low power; others reserved.
// - Timestamp control bit 0 enables input receiver; register resets 0x00.
// - Timestamp control bit 1 selects low-swing receive mode, reset 0.
// - Reference output runs only with its enable and PLL enable set.
// - Reference output enable resets to 1; register resets 0x01.
`timescale 1ns/100ps
`include "ccr_map.vh"
module ccr_config_regs
(
  input wire CLOCK,
  input wire RST_N,
  input wire WR_EN,
  input wire RD_EN,
  input wire [7:0] ADDR,
  input wire [23:0] WR_DATA,
  input wire EDGE_CAPTURE_VALID,
  input wire [23:0] EDGE_CAPTURE_WORD,
  input wire PLL_ENABLE,
  output reg [23:0] RD_DATA,
  output reg RD_VALID,
  output reg [15:0] FULLSCALE_RANGE_CODE,
  output reg [7:0] POWER_PROFILE_CODE,
  output reg POWER_PROFILE_LOW,
  output reg TIMESTAMP_INPUT_ENABLE,
  output reg TIMESTAMP_LOW_SWING_MODE,
  output reg REF_CLOCK_OUTPUT_ENABLE,
  output reg [7:0] PLL_FEEDBACK_DIVIDER_VP
);
  wire [23:0] sysref_edge_status;
  wire sel_fullscale;
  wire sel_profile;
  wire sel_timestamp;
  wire sel_refout;
  wire sel_fbdiv;
  wire wr_fullscale;
  wire wr_profile;
  wire wr_timestamp;
  wire wr_refout;
  wire wr_fbdiv;
  reg [7:0] timestamp_ctrl;
  reg [7:0] refout_ctrl;
  reg [23:0] next_rd_data;

  ccr_status_hold u_status
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .load(EDGE_CAPTURE_VALID),
    .load_data(EDGE_CAPTURE_WORD),
    .held(sysref_edge_status)
  );

  // Address decode
  assign sel_fullscale = (ADDR == `CCR_ADDR_FULLSCALE);
  assign sel_profile = (ADDR == `CCR_ADDR_POWER_PROFILE);
  assign sel_timestamp = (ADDR == `CCR_ADDR_TIMESTAMP_CTRL);
  assign sel_refout = (ADDR == `CCR_ADDR_REFOUT_CTRL);
  assign sel_fbdiv = (ADDR == `CCR_ADDR_FBDIV_VP);

  assign wr_fullscale = WR_EN & sel_fullscale;
  assign wr_profile = WR_EN & sel_profile;
  assign wr_timestamp = WR_EN & sel_timestamp;
  assign wr_refout = WR_EN & sel_refout;
  assign wr_fbdiv = WR_EN & sel_fbdiv;

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      FULLSCALE_RANGE_CODE <= `CCR_RST_FULLSCALE;
    end
    else if (wr_fullscale)
    begin
      FULLSCALE_RANGE_CODE <= WR_DATA[15:0];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      POWER_PROFILE_CODE <= `CCR_RST_POWER_PROFILE;
    end
    else if (wr_profile)
    begin
      POWER_PROFILE_CODE <= WR_DATA[7:0];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      timestamp_ctrl <= `CCR_RST_TIMESTAMP_CTRL;
    end
    else if (wr_timestamp)
    begin
      timestamp_ctrl <= WR_DATA[7:0];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      refout_ctrl <= `CCR_RST_REFOUT_CTRL;
    end
    else if (wr_refout)
    begin
      refout_ctrl <= WR_DATA[7:0];
    end
  end

  // Divider register store
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PLL_FEEDBACK_DIVIDER_VP <= `CCR_RST_FBDIV_VP;
    end
    else if (wr_fbdiv)
    begin
      PLL_FEEDBACK_DIVIDER_VP <= WR_DATA[7:0];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      POWER_PROFILE_LOW <= 1'b0;
    end
    else
    begin
      POWER_PROFILE_LOW <= (POWER_PROFILE_CODE == `CCR_PROFILE_LOW_POWER);
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TIMESTAMP_INPUT_ENABLE <= 1'b0;
    end
    else
    begin
      TIMESTAMP_INPUT_ENABLE <= timestamp_ctrl[`CCR_BIT_TS_ENABLE];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TIMESTAMP_LOW_SWING_MODE <= 1'b0;
    end
    else
    begin
      TIMESTAMP_LOW_SWING_MODE <= timestamp_ctrl[`CCR_BIT_TS_LOW_SWING];
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REF_CLOCK_OUTPUT_ENABLE <= 1'b0;
    end
    else
    begin
      REF_CLOCK_OUTPUT_ENABLE <= refout_ctrl[`CCR_BIT_REFOUT_ENABLE] & PLL_ENABLE;
    end
  end

  // Read mux
  always @*
  begin
    next_rd_data = 24'h00_0000;
    case (ADDR)
      `CCR_ADDR_SYSREF_STATUS: next_rd_data = sysref_edge_status;
      `CCR_ADDR_FULLSCALE: next_rd_data = {8'h00, FULLSCALE_RANGE_CODE};
      `CCR_ADDR_POWER_PROFILE: next_rd_data = {16'h0000, POWER_PROFILE_CODE};
      `CCR_ADDR_TIMESTAMP_CTRL: next_rd_data = {16'h0000, timestamp_ctrl};
      `CCR_ADDR_REFOUT_CTRL: next_rd_data = {16'h0000, refout_ctrl};
      `CCR_ADDR_FBDIV_VP: next_rd_data = {16'h0000, PLL_FEEDBACK_DIVIDER_VP};
      default: next_rd_data = 24'h00_0000;
    endcase
  end

  // Read strobe echo, one cycle
  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_VALID <= 1'b0;
    end
    else
    begin
      RD_VALID <= RD_EN;
    end
  end

  always @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_DATA <= 24'h00_0000;
    end
    else if (RD_EN)
    begin
      RD_DATA <= next_rd_data;
    end
  end
endmodule // ccr_config_regs

/* File: verif/ccr_config_regs_chk.sv */
`timescale 1ns/100ps
module ccr_chk
(
  input wire CLOCK,
  input wire RST_N,
  input wire WR_EN,
  input wire RD_EN,
  input wire EDGE_CAPTURE_VALID,
  input wire PLL_ENABLE,
  input wire POWER_PROFILE_LOW,
  input wire TIMESTAMP_INPUT_ENABLE,
  input wire TIMESTAMP_LOW_SWING_MODE,
  input wire REF_CLOCK_OUTPUT_ENABLE,
  input wire [7:0] ADDR,
  input wire [7:0] POWER_PROFILE_CODE,
  input wire [15:0] FULLSCALE_RANGE_CODE,
  input wire [23:0] WR_DATA,
  input wire [23:0] EDGE_CAPTURE_WORD,
  input wire [23:0] RD_DATA
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_cap; EDGE_CAPTURE_VALID ##1 RD_EN&&ADDR==8'h2C&&!EDGE_CAPTURE_VALID; endsequence
  property p_cap; s_cap |=> RD_DATA==$past(EDGE_CAPTURE_WORD,2); endproperty
  a_cap: assert property(p_cap) else $error("status");
  property p_fsw; WR_EN&&ADDR==8'h30 |=> FULLSCALE_RANGE_CODE==$past(WR_DATA[15:0]); endproperty
  a_fsw: assert property(p_fsw) else $error("fs");
  property p_fsr; RD_EN&&ADDR==8'h30 |=> RD_DATA=={8'h00,$past(FULLSCALE_RANGE_CODE)}; endproperty
  a_fsr: assert property(p_fsr) else $error("fs rd");
  property p_pw; WR_EN&&ADDR==8'h37 |=> POWER_PROFILE_CODE==$past(WR_DATA[7:0]); endproperty
  a_pw: assert property(p_pw) else $error("prof");
  property p_low; 1'b1 |=> POWER_PROFILE_LOW==($past(POWER_PROFILE_CODE)==8'h46); endproperty
  a_low: assert property(p_low) else $error("low");
  property p_tse; WR_EN&&ADDR==8'h3B |=> ##1 TIMESTAMP_INPUT_ENABLE==$past(WR_DATA[0],2); endproperty
  a_tse: assert property(p_tse) else $error("ts en");
  property p_tsl; WR_EN&&ADDR==8'h3B |=> ##1 TIMESTAMP_LOW_SWING_MODE==$past(WR_DATA[1],2);
  endproperty
  a_tsl: assert property(p_tsl) else $error("ts ls");
  property p_ref; !PLL_ENABLE |=> !REF_CLOCK_OUTPUT_ENABLE; endproperty
  a_ref: assert property(p_ref) else $error("ref");
endmodule // ccr_chk
bind ccr_config_regs ccr_chk chk
(
  .CLOCK(CLOCK),
  .RST_N(RST_N),
  .WR_EN(WR_EN),
  .RD_EN(RD_EN),
  .EDGE_CAPTURE_VALID(EDGE_CAPTURE_VALID),
  .PLL_ENABLE(PLL_ENABLE),
  .POWER_PROFILE_LOW(POWER_PROFILE_LOW),
  .TIMESTAMP_INPUT_ENABLE(TIMESTAMP_INPUT_ENABLE),
  .TIMESTAMP_LOW_SWING_MODE(TIMESTAMP_LOW_SWING_MODE),
  .REF_CLOCK_OUTPUT_ENABLE(REF_CLOCK_OUTPUT_ENABLE),
  .ADDR(ADDR),
  .POWER_PROFILE_CODE(POWER_PROFILE_CODE),
  .FULLSCALE_RANGE_CODE(FULLSCALE_RANGE_CODE),
  .WR_DATA(WR_DATA),
  .EDGE_CAPTURE_WORD(EDGE_CAPTURE_WORD),
  .RD_DATA(RD_DATA)
);

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  reg clock=0,rst_n=0,wr_en=0,rd_en=0,cap_v=0,pll_en=0;
  reg [7:0] addr=0;
  reg [23:0] wr_data=0,cap_w=0;
  wire [23:0] rd_data;
  wire rd_valid,low,ts_en,ts_ls,ref_en;
  wire [15:0] fs;
  wire [7:0] prof;
  wire [7:0] fbdiv;
  integer errors=0,n_tests=0,cyc=0;
  always #12.5 clock=~clock;
  ccr_config_regs uut(.CLOCK(clock),.RST_N(rst_n),.WR_EN(wr_en),.RD_EN(rd_en),.ADDR(addr),
    .WR_DATA(wr_data),.EDGE_CAPTURE_VALID(cap_v),.EDGE_CAPTURE_WORD(cap_w),.PLL_ENABLE(pll_en),
    .RD_DATA(rd_data),.RD_VALID(rd_valid),.FULLSCALE_RANGE_CODE(fs),.POWER_PROFILE_CODE(prof),
    .POWER_PROFILE_LOW(low),.TIMESTAMP_INPUT_ENABLE(ts_en),.TIMESTAMP_LOW_SWING_MODE(ts_ls),
    .REF_CLOCK_OUTPUT_ENABLE(ref_en),.PLL_FEEDBACK_DIVIDER_VP(fbdiv));
  task chk(input [63:0] nm,input [23:0] e,input [23:0] g);
  begin
    n_tests=n_tests+1;
    if(g!==e)
    begin
      errors=errors+1;
      $display("mismatch %0s exp %h got %h",nm,e,g);
    end
  end
  endtask
  task wr(input [7:0] a,input [23:0] d);
  begin
    addr=a; wr_data=d; wr_en=1; @(negedge clock); wr_en=0;
    @(negedge clock);
  end
  endtask
  task rd(input [7:0] a,input [23:0] e);
  begin
    addr=a; rd_en=1; @(negedge clock); rd_en=0;
    chk("valid",24'h1,{23'h0,rd_valid}); chk("rd_data",e,rd_data);
    @(negedge clock);
  end
  endtask
  task report_and_stop;
  begin
    $display("tests %0d errors %0d",n_tests,errors);
    if(errors==0&&n_tests>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cyc=cyc+1;
    if(cyc==500)
    begin
      errors=errors+1; report_and_stop;
    end
  end
  initial
  begin
    repeat(3) @(negedge clock);
    rst_n=1;
    rd(8'h2C,24'h0); rd(8'h30,24'h00_A000); rd(8'h37,24'h00_004B);
    rd(8'h3B,24'h0); rd(8'h3C,24'h00_0001); rd(8'h3D,24'h0); rd(8'h40,24'h0);
    chk("prof",24'h00_004B,{16'h0,prof}); chk("fbdiv",24'h0,{16'h0,fbdiv});
    $display("reset test done");
    pll_en=1; wr(8'h2C,24'hFF_FFFF); rd(8'h2C,24'h0);
    chk("ref_en",24'h1,{23'h0,ref_en});
    cap_w=24'h5A_C3F0; cap_v=1; @(negedge clock); cap_v=0;
    rd(8'h2C,24'h5A_C3F0);
    wr(8'h30,24'h00_2000); rd(8'h30,24'h00_2000);
    chk("fs",24'h00_2000,{8'h0,fs});
    $display("status test done");
    wr(8'h37,24'h00_0046); @(negedge clock); chk("low",24'h1,{23'h0,low});
    chk("prof",24'h00_0046,{16'h0,prof});
    wr(8'h37,24'h00_004B); @(negedge clock); chk("low",24'h0,{23'h0,low});
    wr(8'h3B,24'h00_0003); @(negedge clock); chk("ts",24'h3,{22'h0,ts_ls,ts_en});
    wr(8'h3B,24'h00_0002); @(negedge clock); chk("ts",24'h2,{22'h0,ts_ls,ts_en});
    wr(8'h3C,24'h0); @(negedge clock); chk("ref_en",24'h0,{23'h0,ref_en});
    wr(8'h3C,24'h1); chk("ref_en",24'h1,{23'h0,ref_en});
    pll_en=0; @(negedge clock); chk("ref_en",24'h0,{23'h0,ref_en});
    wr(8'h3D,24'h00_0006); rd(8'h3D,24'h00_0006);
    chk("fbdiv",24'h00_0006,{16'h0,fbdiv});
    $display("control test done");
    report_and_stop;
  end
endmodule // tb_top
